// ==== core/evt_consts.svh ====
// Constants for the exception vector table block.
// Assumes inclusion by bare name from core/.
`ifndef EVT_CONSTS_SVH
`define EVT_CONSTS_SVH
`define EVT_TABLE_BASE      24'h008000
`define EVT_DEBUG_HANDLER   24'hFFFC00
`define EVT_OFF_BASE        24'hFFFF80
`define EVT_OFF_CORE_TYPE   24'hFFFF84
`define EVT_OFF_IRQ_STATUS  24'hFFFF88
`define EVT_OFF_IRQ_ENABLE  24'hFFFF8C
`define EVT_OFF_IRQ_CLEAR   24'hFFFF90
`define EVT_OFF_CTRL        24'hFFFF94
`define EVT_OFF_VECTOR      24'hFFFF98
`define EVT_VEC_RESET       5'h00
`define EVT_VEC_MISALIGN    5'h01
`define EVT_VEC_NMI         5'h02
`define EVT_VEC_PERIPH0     5'h04
`define EVT_CTRL_WDT_NMI    0
`define EVT_ST_ACCEPT       0
`define EVT_ST_RESET        1
`define EVT_ST_UNMAPPED     2
`define EVT_STATUS_W        3
`define EVT_VECTOR_STRIDE   2
`endif

// ==== core/evt_pkg.sv ====
// Types for the exception vector table block.
// Assumes evt_consts.svh holds the addresses, vector numbers and bit indices; source codes are set here.
package evt_pkg;
  typedef enum logic [2:0] {
    EVT_SRC_NONE     = 3'b000,
    EVT_SRC_RESET    = 3'b001,
    EVT_SRC_MISALIGN = 3'b010,
    EVT_SRC_DEBUG    = 3'b011,
    EVT_SRC_NMI      = 3'b100,
    EVT_SRC_MASKABLE = 3'b101
  } evt_src_t;
  typedef struct packed {
    logic     valid;
    evt_src_t src;
    logic [4:0] vector;
    logic [23:0] address;
  } evt_req_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [23:0] paddr;
    logic [31:0] pwdata;
  } evt_apb_req_t;
endpackage : evt_pkg

// ==== core/evt_prio_enc.sv ====
// Lowest-index-wins priority encoder over a request vector.
// Assumes requests are already qualified by the caller.
`timescale 1ns/1ns
`default_nettype none
module evt_prio_enc #(
  parameter int N = 16,
  parameter int W = 4
) (
  // Requests
  input  wire logic [N-1:0] req,
  // Result
  output logic             any,
  output logic [W-1:0]     idx
);
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = W'(i);
      end
    end
  end
endmodule : evt_prio_enc
`default_nettype wire

// ==== core/evt_vector_table.sv ====
// Exception vector resolution and table base / core type registers.
// Assumes APB master on pclk; peripheral and event inputs are asynchronous pins.
// Operation
// - After any reset the first fetch address is table entry zero.
// - The vector table sits at fixed base 0x8000.
// - Base register at 0xffff80 reads base in 23:0, zero above.
// - Vector n handler address is base plus four times n.
// - Reset pin takes vector 0 at 0x8000 with top priority.
// - Priority: reset, misaligned, debug at 0xfffc00, then watchdog NMI.
// - Software selects whether watchdog overflow goes to reset or NMI.
// - Peripheral interrupts use vectors 4 to 19; 3 and 20-31 reserved.
// - Several causes of one peripheral share its single vector.
// - Among equal-level maskable requests the lower vector wins.
// - Core type register at 0xffff84 returns a fixed code.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "evt_consts.svh"
module evt_vector_table
  import evt_pkg::*;
#(
  parameter int          NUM_PERIPH  = 16,
  parameter int          NUM_CAUSES  = 4,
  parameter logic [7:0]  CORE_TYPE   = 8'h5A   // Arbitrary value
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clk_en,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [23:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Event sources (asynchronous)
  input  wire logic                  reset_pin_n,
  input  wire logic                  wdt_overflow,
  input  wire logic                  misalign_req,
  input  wire logic                  debug_req,
  input  wire logic [NUM_PERIPH*NUM_CAUSES-1:0] periph_cause,
  // Core interface
  input  wire logic                  core_ack,
  output evt_req_t                   core_req,
  output logic                       boot_pending,
  output logic                       wdt_reset_out,
  // Interrupt
  output logic                       irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SW = NUM_PERIPH * NUM_CAUSES + 4;
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= {{(SW-1){1'b0}}, 1'b1};
      sync2 <= {{(SW-1){1'b0}}, 1'b1};
    end else if (clk_en) begin
      sync1 <= {periph_cause, debug_req, misalign_req, wdt_overflow, reset_pin_n};
      sync2 <= sync1;
    end
  end
  logic                             rst_pin_n_s;
  logic                             wdt_s;
  logic                             mis_s;
  logic                             dbg_s;
  logic [NUM_PERIPH*NUM_CAUSES-1:0] cause_s;
  assign rst_pin_n_s = sync2[0];
  assign wdt_s       = sync2[1];
  assign mis_s       = sync2[2];
  assign dbg_s       = sync2[3];
  assign cause_s     = sync2[SW-1:4];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic apb_acc;
  logic apb_wr;
  logic hit_base;
  logic hit_type;
  logic hit_stat;
  logic hit_en;
  logic hit_clr;
  logic hit_ctrl;
  logic hit_vec;
  logic hit_any;
  assign apb_acc  = psel & penable & clk_en;
  assign apb_wr   = apb_acc & pwrite;
  assign hit_base = paddr == `EVT_OFF_BASE;
  assign hit_type = paddr == `EVT_OFF_CORE_TYPE;
  assign hit_stat = paddr == `EVT_OFF_IRQ_STATUS;
  assign hit_en   = paddr == `EVT_OFF_IRQ_ENABLE;
  assign hit_clr  = paddr == `EVT_OFF_IRQ_CLEAR;
  assign hit_ctrl = paddr == `EVT_OFF_CTRL;
  assign hit_vec  = paddr == `EVT_OFF_VECTOR;
  assign hit_any  = hit_base | hit_type | hit_stat | hit_en | hit_clr | hit_ctrl | hit_vec;
  // Zero wait states; clk_en low in the access phase stalls the access, but clk_en low in a read's setup cycle leaves prdata stale
  assign pready   = clk_en;
  assign pslverr  = psel & penable & ~hit_any;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic wdt_to_nmi;
  logic [NUM_PERIPH-1:0] periph_mask;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_to_nmi <= 1'b0;
    end else if (clk_en && apb_wr && hit_ctrl) begin
      wdt_to_nmi <= pwdata[`EVT_CTRL_WDT_NMI];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_mask <= '0;
    end else if (clk_en && apb_wr && hit_en) begin
      periph_mask <= pwdata[NUM_PERIPH+15:16];
    end
  end

  // ----------------------------------------------------------------
  // Event sources and priority
  // ----------------------------------------------------------------
  logic [NUM_PERIPH-1:0] periph_req;
  always_comb begin
    for (int p = 0; p < NUM_PERIPH; p++) begin
      periph_req[p] = |cause_s[p*NUM_CAUSES +: NUM_CAUSES] & periph_mask[p];
    end
  end
  logic       p_any;
  logic [3:0] p_idx;
  evt_prio_enc #(.N(NUM_PERIPH), .W(4)) u_prio (
    .req (periph_req),
    .any (p_any),
    .idx (p_idx)
  );

  logic wdt_rise;
  logic wdt_d;
  logic boot;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_d <= 1'b0;
    end else if (clk_en) begin
      wdt_d <= wdt_s;
    end
  end
  assign wdt_rise      = wdt_s & ~wdt_d;
  assign wdt_reset_out = wdt_rise & ~wdt_to_nmi;

  // ----------------------------------------------------------------
  // Watchdog NMI pending
  // ----------------------------------------------------------------
  // The overflow is a one-cycle edge; without this latch a misaligned or
  // debug request standing in front of it would swallow the NMI for good
  logic nmi_pend;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_pend <= 1'b0;
    end else if (clk_en) begin
      if (wdt_rise && wdt_to_nmi) begin
        nmi_pend <= 1'b1;
      end else if (core_ack && core_req.src == EVT_SRC_NMI) begin
        nmi_pend <= 1'b0;
      end
    end
  end

  logic reset_evt;
  assign reset_evt = ~rst_pin_n_s | boot | (wdt_rise & ~wdt_to_nmi);

  function automatic logic [23:0] vec_addr(input logic [4:0] n);
    vec_addr = `EVT_TABLE_BASE + {17'h00000, n, 2'b00};
  endfunction : vec_addr

  evt_req_t next_req;
  always_comb begin
    next_req = '0;
    if (reset_evt) begin
      next_req = '{1'b1, EVT_SRC_RESET, `EVT_VEC_RESET, vec_addr(`EVT_VEC_RESET)};
    end else if (mis_s) begin
      next_req = '{1'b1, EVT_SRC_MISALIGN, `EVT_VEC_MISALIGN, vec_addr(`EVT_VEC_MISALIGN)};
    end else if (dbg_s) begin
      next_req = '{1'b1, EVT_SRC_DEBUG, 5'h00, `EVT_DEBUG_HANDLER};
    end else if (nmi_pend || (wdt_rise && wdt_to_nmi)) begin
      next_req = '{1'b1, EVT_SRC_NMI, `EVT_VEC_NMI, vec_addr(`EVT_VEC_NMI)};
    end else if (p_any) begin
      next_req = '{1'b1, EVT_SRC_MASKABLE, `EVT_VEC_PERIPH0 + {1'b0, p_idx},
                   vec_addr(`EVT_VEC_PERIPH0 + {1'b0, p_idx})};
    end
  end

  // Boot request stays up after any reset until the core takes the first
  // fetch address; a reset that is still held re-arms it, so set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot <= 1'b1;
    end else if (clk_en) begin
      if (!rst_pin_n_s || wdt_reset_out) begin
        boot <= 1'b1;
      end else if (core_ack && core_req.src == EVT_SRC_RESET) begin
        boot <= 1'b0;
      end
    end
  end
  assign boot_pending = boot;

  // Registered request to the core; a non-acked request may be replaced by a higher one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_req <= '{1'b1, EVT_SRC_RESET, `EVT_VEC_RESET, `EVT_TABLE_BASE};
    end else if (clk_en) begin
      core_req <= next_req;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, enable, clear
  // ----------------------------------------------------------------
  logic [`EVT_STATUS_W-1:0] irq_status;
  logic [`EVT_STATUS_W-1:0] irq_enable;
  logic [`EVT_STATUS_W-1:0] irq_set;
  logic [`EVT_STATUS_W-1:0] irq_clr;
  always_comb begin
    irq_set = '0;
    irq_set[`EVT_ST_ACCEPT]   = core_ack & core_req.valid;
    irq_set[`EVT_ST_RESET]    = wdt_reset_out;
    irq_set[`EVT_ST_UNMAPPED] = apb_acc & ~hit_any;
    irq_clr = (apb_wr && hit_clr) ? pwdata[`EVT_STATUS_W-1:0] : '0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else if (clk_en) begin
      // Set beats clear so an event landing on the clear write is kept
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable <= '0;
    end else if (clk_en && apb_wr && hit_en) begin
      irq_enable <= pwdata[`EVT_STATUS_W-1:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(((irq_status & ~irq_clr) | irq_set) & irq_enable);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (1'b1)
      hit_base: next_rdata = {8'h00, `EVT_TABLE_BASE};
      hit_type: next_rdata = {24'h000000, CORE_TYPE};
      hit_stat: next_rdata = {29'h00000000, irq_status};
      hit_en:   next_rdata = {16'h0000, periph_mask} | {29'h00000000, irq_enable};
      hit_ctrl: next_rdata = {31'h00000000, wdt_to_nmi};
      hit_vec:  next_rdata = {core_req.valid, 2'b00, core_req.vector, core_req.address};
      default:  next_rdata = 32'h00000000;
    endcase
  end
  // Writes to base and core type fall through with no effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end
  end

endmodule : evt_vector_table
`default_nettype wire

// ==== testbench/evt_core_model.sv ====
// Core model: takes handler requests promptly or two cycles late.
// Assumes the pclk domain and the evt_pkg request struct.
`timescale 1ns/1ns
`default_nettype none
module evt_core_model
  import evt_pkg::*;
(
  // Clock and reset
  input  wire logic     pclk,
  input  wire logic     presetn,
  // Bench control
  input  wire logic     en,
  input  wire logic     slow,
  // Vector request
  input  wire evt_req_t req,
  output logic          ack
);
  logic [1:0] cnt;
  // One-cycle ack pulse; the wait restarts after each take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack <= 1'b0;
      cnt <= 2'h0;
    end else begin
      ack <= en && req.valid && !ack && cnt >= (slow ? 2'h2 : 2'h0);
      cnt <= (en && req.valid && !ack) ? cnt + 2'h1 : 2'h0;
    end
  end
endmodule : evt_core_model
`default_nettype wire

// ==== testbench/evt_sva.sv ====
// Checker: vector resolution and fixed register reads at the block ports.
// Assumes bind onto evt_vector_table; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module evt_sva
  import evt_pkg::*;
#(parameter logic [7:0] CORE_TYPE = 8'h5A) (
  // Clock, reset, APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [23:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Events and core
  input wire logic        reset_pin_n,
  input wire evt_req_t    core_req,
  input wire logic        boot_pending
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic     rd  = psel && penable && pready && !pwrite;
  evt_src_t      src;
  assign src = core_req.src;
  boot_vec_a: assert property (boot_pending |-> src == EVT_SRC_RESET && core_req.address == 24'h008000)
    else $error("boot request not at entry zero");
  vec_addr_a: assert property (core_req.valid && src != EVT_SRC_DEBUG && src != EVT_SRC_NONE
    |-> core_req.address == 24'h008000 + {17'h0, core_req.vector, 2'b00}) else $error("vector address off");
  debug_addr_a: assert property (src == EVT_SRC_DEBUG |-> core_req.address == 24'hFFFC00)
    else $error("debug handler address wrong");
  nmi_vec_a: assert property (src == EVT_SRC_NMI |-> core_req.vector == 5'h02)
    else $error("nmi vector wrong");
  mask_range_a: assert property (src == EVT_SRC_MASKABLE |-> core_req.vector inside {[5'h04:5'h13]})
    else $error("maskable vector out of range");
  pin_reset_a: assert property ($fell(reset_pin_n) |-> ##[1:4] src == EVT_SRC_RESET)
    else $error("reset pin not taken");
  base_read_a: assert property (rd && paddr == 24'hFFFF80 |-> prdata == 32'h00008000)
    else $error("base register read wrong");
  ident_read_a: assert property (rd && paddr == 24'hFFFF84 |-> prdata == {24'h0, CORE_TYPE})
    else $error("core type read wrong");
endmodule : evt_sva
bind evt_vector_table evt_sva #(.CORE_TYPE(CORE_TYPE)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .reset_pin_n(reset_pin_n), .core_req(core_req), .boot_pending(boot_pending));
`default_nettype wire

// ==== testbench/tb.sv ====
// Testbench: APB register checks and vector resolution scenarios.
// Assumes a core model that acks on request; clk_en is dropped once to check the freeze.
`timescale 1ns/1ns
`default_nettype none
module tb
  import evt_pkg::*;
();
  localparam logic [7:0] CT = 8'h3C;  // Arbitrary core type code
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pin_n = 1'b1, wdt = 1'b0, mis = 1'b0, dbg = 1'b0, en = 1'b0, slow = 1'b1, cen = 1'b1;
  logic [23:0] paddr = 24'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [63:0] cause = 64'h0;
  logic        pready, pslverr, ack, boot, wdt_rst, irq;
  evt_req_t    req;
  int          n_fail = 0, n_tests = 0;

  evt_vector_table #(.CORE_TYPE(CT)) dut (.pclk(pclk), .presetn(presetn), .clk_en(cen), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin_n(pin_n), .wdt_overflow(wdt), .misalign_req(mis), .debug_req(dbg),
    .periph_cause(cause), .core_ack(ack), .core_req(req), .boot_pending(boot), .wdt_reset_out(wdt_rst),
    .irq(irq));
  evt_core_model cpu (.pclk(pclk), .presetn(presetn), .en(en), .slow(slow), .req(req), .ack(ack));

  initial forever #25 pclk = ~pclk;

  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Bounded wait for pready (sel 0) or the core's ack (sel 1)
  task await(input logic sel);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while ((sel ? ack : pready) !== 1'b1 && k < 16);
    if (k >= 16) begin
      chk("handshake", 32'h1, 32'h0);
      complete_run();
    end
  endtask : await

  task apb(input logic wr, input logic [23:0] a, input logic [31:0] d, input logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    await(1'b0);
    q = prdata;
    chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task take;
    en <= 1'b1;
    await(1'b1);
    en <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : take

  initial begin
    logic seen;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("boot address", 32'h8000, {8'h0, req.address});
    take();
    chk("boot pending", 32'h0, {31'h0, boot});
    slow <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 24'hFFFF80 + 24'(4 * i), 32'hFFFFFFFF, 1'b0);
      apb(1'b0, 24'hFFFF80 + 24'(4 * i), 32'h0, 1'b0);
      chk("fixed register", i ? {24'h0, CT} : 32'h00008000, q);
    end
    // Unmapped access raises status bit 2, then enable, mask and clear it
    apb(1'b0, 24'hFFFF00, 32'h0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, i == 2 ? 24'hFFFF90 : 24'hFFFF8C, i == 1 ? 32'hFFFF0000 : 32'hFFFF0004, 1'b0);
      repeat (2) @(posedge pclk);
      chk("irq", {31'h0, i == 0}, {31'h0, irq});
    end
    apb(1'b0, 24'hFFFF88, 32'h0, 1'b0);
    chk("status", 32'h1, q);
    for (int p = 0; p < 16; p++) begin
      cause <= (64'h1 << (4 * p + p % 4)) | 64'h8000000000000000;
      repeat (4) @(posedge pclk);
      chk("maskable address", 32'h8010 + 32'(4 * p), {8'h0, req.address});
    end
    cause <= 64'h1;
    mis <= 1'b1;
    dbg <= 1'b1;
    apb(1'b1, 24'hFFFF94, 32'h1, 1'b0);
    wdt <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("misaligned", 32'h8004, {8'h0, req.address});
    mis <= 1'b0;
    take();
    chk("debug", 32'hFFFC00, {8'h0, req.address});
    dbg <= 1'b0;
    take();
    chk("nmi", 32'h8008, {8'h0, req.address});
    take();
    chk("after nmi", 32'h8010, {8'h0, req.address});
    cause <= 64'h0;
    wdt <= 1'b0;
    apb(1'b1, 24'hFFFF94, 32'h0, 1'b0);
    wdt <= 1'b1;
    seen = 1'b0;
    repeat (8) begin
      @(posedge pclk);
      seen = seen | (wdt_rst === 1'b1);
    end
    chk("watchdog reset", 32'h1, {31'h0, seen});
    wdt <= 1'b0;
    apb(1'b0, 24'hFFFF88, 32'h0, 1'b0);
    chk("status after watchdog", 32'h3, q);
    chk("boot after watchdog", 32'h1, {31'h0, boot});
    take();
    chk("boot taken", 32'h0, {31'h0, boot});
    // Clock enable low must freeze the synchronisers and the request
    cen <= 1'b0;
    cause <= 64'h1;
    repeat (6) @(posedge pclk);
    chk("frozen request", 32'h0, {8'h0, req.address});
    cen <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("thawed request", 32'h8010, {8'h0, req.address});
    cause <= 64'h0;
    pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("pin reset", 32'h8000, {8'h0, req.address});
    apb(1'b0, 24'hFFFF98, 32'h0, 1'b0);
    chk("vector register", 32'h80008000, q);
    pin_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("boot after pin", 32'h1, {31'h0, boot});
    chk("boot address after pin", 32'h8000, {8'h0, req.address});
    take();
    apb(1'b1, 24'hFFFF94, 32'h1, 1'b0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("boot after presetn", 32'h1, {31'h0, boot});
    apb(1'b0, 24'hFFFF94, 32'h0, 1'b0);
    chk("ctrl after presetn", 32'h0, q);
    complete_run();
  end
endmodule : tb
`default_nettype wire
